// ===== rtl/rx_fifo.v
// =====================================
// receive character store, 16 deep
module rx_fifo (
   input wire clock,
   input wire rst_b,
   input wire flush,
   input wire push,
   input wire [7:0] push_data,
   input wire pop,
   output wire [7:0] head,
   output wire full,
   output wire empty,
   output wire [4:0] count
);
   reg [7:0] mem [0:15];
   reg [3:0] wr_q;
   reg [3:0] rd_q;
   reg [4:0] cnt_q;
   wire do_push;
   wire do_pop;
   assign full = (cnt_q == 5'h10);
   assign empty = (cnt_q == 5'h00);
   assign count = cnt_q;
   assign head = mem[rd_q];
   assign do_push = push && !full;
   assign do_pop = pop && !empty;
   always @(posedge clock) begin
      if (do_push) begin
         mem[wr_q] <= push_data;
      end
   end
   always @(posedge clock) begin
      if (!rst_b || flush) begin
         wr_q <= 4'h0;
         rd_q <= 4'h0;
         cnt_q <= 5'h00;
      end else begin
         if (do_push) begin
            wr_q <= wr_q + 4'h1;
         end
         if (do_pop) begin
            rd_q <= rd_q + 4'h1;
         end
         if (do_push && !do_pop) begin
            cnt_q <= cnt_q + 5'h01;
         end else if (do_pop && !do_push) begin
            cnt_q <= cnt_q - 5'h01;
         end
      end
   end
endmodule

// ===== rtl/uart_channel.v
// Design decision made here: the AXI4-Lite slave port.
`include "uart_defines.vh"
module uart_channel (
   input wire clock,
   input wire rst_b,
   input wire [5:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [5:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire serial_in,
   output reg serial_out,
   input wire cts_n,
   input wire dsr_n,
   input wire ri_n,
   input wire dcd_n,
   output reg rts_n,
   output reg dtr_n,
   output reg irq
);
   // =====================================
   // registers
   reg [7:0] ier_q, lcr_q, mcr_q, scr_q, dll_q, dlm_q;
   reg fifo_en_q;
   reg [1:0] trig_q;
   reg [7:0] thr_q;
   reg thr_full_q;
   reg oe_q, pe_q, fe_q, bi_q;
   reg holding_empty_flag_irq_q;
   reg [3:0] msr_delta_q;
   reg [3:0] modem_prev_q;
   reg [3:0] istat_q, imask_q;
   reg [5:0] awaddr_q, araddr_q;
   reg [31:0] wdata_q;
   reg aw_have_q, w_have_q;
   // =====================================
   // synchronisers
   reg [4:0] sync1_q, sync2_q;
   wire rxd_raw = sync2_q[0];
   wire [3:0] modem_in = ~sync2_q[4:1];
   wire rxd = mcr_q[`MCR_LOOP] ? serial_out : rxd_raw;
   wire [3:0] modem_now = mcr_q[`MCR_LOOP] ?
      {mcr_q[3], mcr_q[2], mcr_q[0], mcr_q[1]} : modem_in;
   always @(posedge clock) begin
      if (!rst_b) begin
         sync1_q <= 5'h1f;
         sync2_q <= 5'h1f;
      end else begin
         sync1_q <= {dcd_n, ri_n, dsr_n, cts_n, serial_in};
         sync2_q <= sync1_q;
      end
   end
   // =====================================
   // 16x baud enable
   reg [15:0] baud_cnt_q;
   wire [15:0] divisor = {dlm_q, dll_q};
   wire tick = (baud_cnt_q == 16'h0001) && (divisor != 16'h0000);
   always @(posedge clock) begin
      if (!rst_b || tick || baud_cnt_q == 16'h0000) begin
         baud_cnt_q <= divisor;
      end else begin
         baud_cnt_q <= baud_cnt_q - 16'h0001;
      end
   end
   // =====================================
   // frame format
   wire [3:0] data_bits = {2'b00, lcr_q[1:0]} + 4'h5;
   wire parity_on = lcr_q[`LCR_PEN];
   // =====================================
   // transmitter
   reg [10:0] tx_sh_q;
   reg [3:0] tx_bits_q;
   reg [3:0] tx_sub_q;
   reg tx_busy_q;
   wire [7:0] tx_mask = 8'hff >> (4'h8 - data_bits);
   wire [7:0] tx_dat = thr_q & tx_mask;
   wire tx_par = lcr_q[5] ? ~lcr_q[4] : (^tx_dat ^ ~lcr_q[4]);
   wire [3:0] tx_total = 4'h1 + data_bits + {3'b000, parity_on} +
      {3'b000, lcr_q[2]} + 4'h1;
   wire tx_load = thr_full_q && !tx_busy_q;
   always @(posedge clock) begin
      if (!rst_b) begin
         tx_sh_q <= 11'h7ff;
         tx_bits_q <= 4'h0;
         tx_sub_q <= 4'h0;
         tx_busy_q <= 1'b0;
         serial_out <= 1'b1;
      end else begin
         if (tx_load) begin
            // lsb follows the start bit directly
            // unused data slots above a short word must idle high
            tx_sh_q <= {2'b11, tx_dat | ~tx_mask, 1'b0};
            if (parity_on) begin
               tx_sh_q[data_bits + 4'h1] <= tx_par;
            end
            tx_bits_q <= tx_total;
            tx_sub_q <= 4'h0;
            tx_busy_q <= 1'b1;
         end else if (tx_busy_q && tick) begin
            tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_sub_q == 4'hf) begin
               tx_sh_q <= {1'b1, tx_sh_q[10:1]};
               tx_bits_q <= tx_bits_q - 4'h1;
               if (tx_bits_q == 4'h1) begin
                  tx_busy_q <= 1'b0;
               end
            end
         end
         serial_out <= lcr_q[`LCR_BREAK] ? 1'b0 :
            (tx_busy_q ? tx_sh_q[0] : 1'b1);
      end
   end
   // =====================================
   // receiver
   reg [3:0] rx_sub_q, rx_bits_q;
   reg rx_busy_q;
   reg [9:0] rx_sh_q;
   reg rx_push_q;
   reg [7:0] rx_byte_q;
   reg rx_pe_q, rx_fe_q, rx_bi_q;
   wire [3:0] rx_total = data_bits + {3'b000, parity_on} + 4'h1;
   // start bit and parity sit around the data in the shifter
   wire [3:0] rx_drop = 4'ha - data_bits - {3'b000, parity_on};
   wire [9:0] rx_align = rx_sh_q >> rx_drop;
   always @(posedge clock) begin
      if (!rst_b) begin
         rx_sub_q <= 4'h0;
         rx_bits_q <= 4'h0;
         rx_busy_q <= 1'b0;
         rx_sh_q <= 10'h000;
         rx_push_q <= 1'b0;
         rx_byte_q <= 8'h00;
         rx_pe_q <= 1'b0;
         rx_fe_q <= 1'b0;
         rx_bi_q <= 1'b0;
      end else begin
         rx_push_q <= 1'b0;
         if (!rx_busy_q) begin
            if (tick && !rxd) begin
               rx_busy_q <= 1'b1;
               rx_sub_q <= 4'h1;
               rx_sh_q <= 10'h000;
               rx_bits_q <= 4'h0;
            end
         end else if (tick) begin
            rx_sub_q <= rx_sub_q + 4'h1;
            if (rx_sub_q == 4'h8) begin
               if (rx_bits_q == 4'h0 && rxd) begin
                  rx_busy_q <= 1'b0;
               end else if (rx_bits_q == rx_total) begin
                  rx_busy_q <= 1'b0;
                  rx_push_q <= 1'b1;
                  rx_byte_q <= rx_align[7:0] & tx_mask;
                  rx_fe_q <= !rxd;
                  rx_bi_q <= !rxd && (rx_sh_q == 10'h000);
                  rx_pe_q <= parity_on && (lcr_q[5] ?
                     (rx_sh_q[9] != ~lcr_q[4]) :
                     (^rx_sh_q[9:0] ^ ~lcr_q[4]) != 1'b0);
               end else begin
                  // first captured bit ends in bit 0 only for eight data bits with parity
                  rx_sh_q <= {rxd, rx_sh_q[9:1]};
               end
               rx_bits_q <= rx_bits_q + 4'h1;
            end
         end
      end
   end
   // =====================================
   // receive store
   wire [7:0] rx_head;
   wire rx_full, rx_empty;
   wire [4:0] rx_count;
   wire rd_data, wr_fcr;
   wire [7:0] wbyte;
   reg rx_flush;
   rx_fifo u_rx_fifo (
      .clock(clock),
      .rst_b(rst_b),
      .flush(rx_flush),
      .push(rx_push_q),
      .push_data(rx_byte_q),
      .pop(rd_data),
      .head(rx_head),
      .full(rx_full),
      .empty(rx_empty),
      .count(rx_count)
   );
   wire rx_limit = fifo_en_q ? rx_full : !rx_empty;
   // =====================================
   // interrupt identification
   wire [4:0] trig_lvl = (trig_q == 2'd0) ? 5'd1 : (trig_q == 2'd1) ?
      5'd4 : (trig_q == 2'd2) ? 5'd8 : 5'd14;
   wire rda = fifo_en_q ? (rx_count >= trig_lvl) : !rx_empty;
   wire ls_src = ier_q[2] && (oe_q | pe_q | fe_q | bi_q);
   wire rd_src = ier_q[0] && rda;
   wire th_src = ier_q[1] && holding_empty_flag_irq_q;
   wire ms_src = ier_q[3] && (msr_delta_q != 4'h0);
   reg [7:0] interrupt_identification;
   always @* begin
      interrupt_identification = `IIR_RESET;
      if (ls_src) begin
         interrupt_identification[3:0] = 4'h6;
      end else if (rd_src) begin
         interrupt_identification[3:0] = 4'h4;
      end else if (th_src) begin
         interrupt_identification[3:0] = 4'h2;
      end else if (ms_src) begin
         interrupt_identification[3:0] = 4'h0;
      end
      // fifo bits only exist in fifo mode
      interrupt_identification[7:6] = fifo_en_q ? 2'b11 : 2'b00;
      interrupt_identification[3] = interrupt_identification[3] & fifo_en_q;
   end
   wire holding_empty_flag = !thr_full_q;
   wire transmitter_idle_flag = holding_empty_flag && !tx_busy_q;
   // in fifo mode an overrun byte never enters the store, so it is not a store error
   wire lsr7 = fifo_en_q && (pe_q | fe_q | bi_q);
   wire [7:0] line_status = {lsr7, transmitter_idle_flag, holding_empty_flag, bi_q, fe_q, pe_q, oe_q,
      !rx_empty};
   wire [7:0] modem_status = {modem_now, msr_delta_q};
   // =====================================
   // axi4-lite write side
   wire wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
   wire [3:0] widx = awaddr_q[5:2];
   wire bank = lcr_q[`LCR_BANK];
   assign wbyte = wdata_q[7:0];
   reg wdata_strb0_q;
   wire wr_lane = wr_go && wdata_strb0_q;
   wire wr_thr = wr_lane && widx == {1'b0, `OFS_DATA} && !bank;
   assign wr_fcr = wr_lane && widx == {1'b0, `OFS_IIR};
   wire rd_go = s_axi_arvalid && s_axi_arready;
   wire [3:0] ridx = s_axi_araddr[5:2];
   assign rd_data = rd_go && ridx == {1'b0, `OFS_DATA} && !bank;
   wire rd_iir = rd_go && ridx == {1'b0, `OFS_IIR};
   wire rd_lsr = rd_go && ridx == {1'b0, `OFS_LSR};
   wire rd_msr = rd_go && ridx == {1'b0, `OFS_MSR};
   wire [3:0] ev = {ms_src, th_src, rd_src, ls_src};
   always @* begin
      rx_flush = wr_fcr && wbyte[`FCR_RXRST];
   end
   always @(posedge clock) begin
      if (!rst_b) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 6'h00;
         wdata_q <= 32'h00000000;
         wdata_strb0_q <= 1'b0;
         ier_q <= 8'h00;
         lcr_q <= 8'h00;
         mcr_q <= 8'h00;
         scr_q <= 8'h00;
         dll_q <= 8'h00;
         dlm_q <= 8'h00;
         fifo_en_q <= 1'b0;
         trig_q <= 2'b00;
         thr_q <= 8'h00;
         thr_full_q <= 1'b0;
         imask_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q <= s_axi_awaddr;
            aw_have_q <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q <= s_axi_wdata;
            wdata_strb0_q <= s_axi_wstrb[0];
            w_have_q <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (widx > `OFS_IMASK) ? 2'b10 : 2'b00;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
         if (tx_load || (wr_fcr && wbyte[`FCR_TXRST])) begin
            thr_full_q <= 1'b0;
         end
         if (wr_lane) begin
            case (widx)
               {1'b0, `OFS_DATA}: begin
                  if (bank) begin
                     dll_q <= wbyte;
                  end else begin
                     thr_q <= wbyte;
                     thr_full_q <= 1'b1;
                  end
               end
               {1'b0, `OFS_IER}: begin
                  if (bank) begin
                     dlm_q <= wbyte;
                  end else begin
                     ier_q <= {4'h0, wbyte[3:0]};
                  end
               end
               {1'b0, `OFS_IIR}: begin
                  // dma select is dropped, reset bits never stored
                  fifo_en_q <= wbyte[`FCR_EN];
                  trig_q <= wbyte[7:6];
               end
               {1'b0, `OFS_LCR}: lcr_q <= wbyte;
               {1'b0, `OFS_MCR}: mcr_q <= {3'b000, wbyte[4:0]};
               {1'b0, `OFS_SCR}: scr_q <= wbyte;
               `OFS_IMASK: imask_q <= wbyte[3:0];
               default: begin
               end
            endcase
         end
      end
   end
   // =====================================
   // status flags, interrupt sources
   always @(posedge clock) begin
      if (!rst_b) begin
         oe_q <= 1'b0;
         pe_q <= 1'b0;
         fe_q <= 1'b0;
         bi_q <= 1'b0;
         holding_empty_flag_irq_q <= 1'b0;
         msr_delta_q <= 4'h0;
         modem_prev_q <= 4'h0;
         istat_q <= 4'h0;
         rts_n <= 1'b1;
         dtr_n <= 1'b1;
         irq <= 1'b0;
      end else begin
         // a new event in the clearing cycle wins
         if (rd_lsr) begin
            {oe_q, pe_q, fe_q, bi_q} <= 4'h0;
         end
         if (rx_push_q) begin
            oe_q <= rx_limit | (oe_q & !rd_lsr);
            pe_q <= rx_pe_q | (pe_q & !rd_lsr);
            fe_q <= rx_fe_q | (fe_q & !rd_lsr);
            bi_q <= rx_bi_q | (bi_q & !rd_lsr);
         end
         if (tx_load) begin
            holding_empty_flag_irq_q <= 1'b1;
         end else if (wr_thr || (rd_iir && interrupt_identification[3:0] == 4'h2)) begin
            holding_empty_flag_irq_q <= 1'b0;
         end
         modem_prev_q <= modem_now;
         msr_delta_q <= (rd_msr ? 4'h0 : msr_delta_q) |
            {modem_now[3] ^ modem_prev_q[3],
             modem_prev_q[2] & !modem_now[2],
             modem_now[1] ^ modem_prev_q[1],
             modem_now[0] ^ modem_prev_q[0]};
         if (wr_lane && widx == `OFS_ISTAT) begin
            istat_q <= (istat_q & ~wbyte[3:0]) | ev;
         end else begin
            istat_q <= istat_q | ev;
         end
         irq <= |(istat_q & imask_q);
         rts_n <= mcr_q[`MCR_LOOP] | !mcr_q[1];
         dtr_n <= mcr_q[`MCR_LOOP] | !mcr_q[0];
      end
   end
   // =====================================
   // axi4-lite read side
   reg [7:0] rmux;
   always @* begin
      rmux = 8'h00;
      case (ridx)
         {1'b0, `OFS_DATA}: rmux = bank ? dll_q : rx_head;
         {1'b0, `OFS_IER}: rmux = bank ? dlm_q : ier_q;
         {1'b0, `OFS_IIR}: rmux = interrupt_identification;
         {1'b0, `OFS_LCR}: rmux = lcr_q;
         {1'b0, `OFS_MCR}: rmux = mcr_q;
         {1'b0, `OFS_LSR}: rmux = line_status;
         {1'b0, `OFS_MSR}: rmux = modem_status;
         {1'b0, `OFS_SCR}: rmux = scr_q;
         `OFS_ISTAT: rmux = {4'h0, istat_q};
         `OFS_IMASK: rmux = {4'h0, imask_q};
         default: rmux = 8'h00;
      endcase
   end
   always @(posedge clock) begin
      if (!rst_b) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'b00;
      end else begin
         if (rd_go) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rmux};
            s_axi_rresp <= (ridx > `OFS_IMASK) ? 2'b10 : 2'b00;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule

// ===== rtl/uart_defines.vh
`ifndef UART_DEFINES_VH
`define UART_DEFINES_VH
// =====================================
// register offsets (byte addresses are 4x)
`define OFS_DATA 3'h0
`define OFS_IER 3'h1
`define OFS_IIR 3'h2
`define OFS_LCR 3'h3
`define OFS_MCR 3'h4
`define OFS_LSR 3'h5
`define OFS_MSR 3'h6
`define OFS_SCR 3'h7
`define OFS_ISTAT 4'h8
`define OFS_IMASK 4'h9
// =====================================
// fields
`define LCR_BANK 7
`define LCR_BREAK 6
`define LCR_PEN 3
`define FCR_EN 0
`define FCR_RXRST 1
`define FCR_TXRST 2
`define FCR_DMA 3
`define MCR_LOOP 4
// =====================================
// reset values, fifo size
`define IIR_RESET 8'h01
`define LSR_RESET 8'h60
`define FIFO_DEPTH 16
`define FIFO_AW 4
`endif

// ===== verification/host_model.sv
// ====
// host side of the register bus
module host_model (
   input wire clock,
   output logic [5:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   output logic s_axi_bready,
   output logic [5:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   output logic s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ns;
   // cycles before the answer is accepted
   int slow = 0;
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 44'h0;
      s_axi_wstrb = 4'hf;
   end
   task automatic wr(input logic [3:0] idx, input logic [7:0] d,
         output logic [1:0] resp);
      @(posedge clock);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (int k = 0; k < 100; k++) begin
         @(posedge clock);
         if (s_axi_bvalid && s_axi_bready) break;
         // released lines must not keep looking valid
         if (s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~s_axi_awaddr;
         end
         if (s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~s_axi_wdata;
         end
         if (k >= slow) s_axi_bready <= 1'b1;
      end
      if (s_axi_bvalid !== 1'b1 || s_axi_bready !== 1'b1)
         uart_channel_register_map_tb.hang();
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] idx, output logic [31:0] data,
         output logic [1:0] resp);
      @(posedge clock);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      for (int k = 0; k < 100; k++) begin
         @(posedge clock);
         if (s_axi_rvalid && s_axi_rready) break;
         if (s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr <= ~s_axi_araddr;
         end
         if (k >= slow) s_axi_rready <= 1'b1;
      end
      if (s_axi_rvalid !== 1'b1 || s_axi_rready !== 1'b1)
         uart_channel_register_map_tb.hang();
      data = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
endmodule

// ===== verification/uart_channel_register_map_tb.sv
`include "uart_defines.vh"
`define compare_eq(g, e) \
   begin \
      comparisons++; \
      if ((g) !== (e)) begin \
         fail_count++; \
         $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); \
      end \
   end
module uart_channel_register_map_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic serial_in = 1'b1;
   logic cts_n = 1'b1, dsr_n = 1'b1, ri_n = 1'b1, dcd_n = 1'b1;
   logic [5:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, data;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, serial_out, rts_n, dtr_n, irq;
   logic [7:0] b, got;
   logic [7:0] rxq[$];
   int fail_count = 0;
   int comparisons = 0;
   int seed = 68950;
   uart_channel uart_channel_i (.*);
   host_model host_model_i (.*);
   always #50 clock = ~clock;
   task automatic test_done();
      if (fail_count == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic hang();
      fail_count++;
      test_done();
   endtask
   task automatic put(input logic [3:0] idx, input logic [7:0] d);
      host_model_i.wr(idx, d, resp);
      `compare_eq(resp, 2'b00)
   endtask
   task automatic expect_rd(input logic [3:0] idx, input logic [7:0] e);
      host_model_i.rd(idx, data, resp);
      `compare_eq({resp, data}, {2'b00, 24'h0, e})
   endtask
   // ====
   // serial line, divisor 1 gives 16 clocks a bit
   task automatic rx_send(input logic [7:0] d);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         serial_in <= f[i];
         repeat (16) @(posedge clock);
      end
      repeat (16) @(posedge clock);
   endtask
   task automatic tx_grab(output logic [7:0] q);
      int n;
      n = 0;
      while (serial_out !== 1'b0 && n < 400) begin
         @(posedge clock);
         n++;
      end
      if (n >= 400) hang();
      for (int i = -1; i < 9; i++) begin
         repeat (i < 0 ? 8 : 16) @(posedge clock);
         if (i >= 0 && i < 8) q[i] = serial_out;
      end
      `compare_eq(serial_out, 1'b1)
      // let the stop bit finish before status is read
      repeat (16) @(posedge clock);
   endtask
   // ====
   // main sequence
   initial begin
      repeat (8) @(posedge clock);
      rst_b <= 1'b1;
      expect_rd(`OFS_IIR, 8'h01);
      expect_rd(`OFS_LSR, 8'h60);
      host_model_i.rd(4'ha, data, resp);
      `compare_eq(resp, 2'b10)
      host_model_i.wr(4'hf, 8'h5a, resp);
      `compare_eq(resp, 2'b10)
      host_model_i.slow = 3;
      b = 8'($random(seed));
      put(`OFS_SCR, b);
      expect_rd(`OFS_SCR, b);
      host_model_i.slow = 0;
      put(`OFS_IER, 8'hff);
      expect_rd(`OFS_IER, 8'h0f);
      put(`OFS_LCR, 8'h83);
      put(`OFS_DATA, 8'h01);
      put(`OFS_IER, 8'h00);
      expect_rd(`OFS_DATA, 8'h01);
      expect_rd(`OFS_LCR, 8'h83);
      put(`OFS_LCR, 8'h03);
      expect_rd(`OFS_IER, 8'h0f);
      put(`OFS_IER, 8'h00);
      put(`OFS_IIR, 8'h08);
      expect_rd(`OFS_IIR, 8'h01);
      for (int t = 0; t < 4; t++) begin
         put(`OFS_IIR, {t[1:0], 6'h0f});
         expect_rd(`OFS_IIR, 8'hc1);
      end
      put(`OFS_IIR, 8'h00);
      expect_rd(`OFS_IIR, 8'h01);
      put(`OFS_IMASK, 8'h00);
      put(`OFS_IER, 8'h02);
      put(`OFS_ISTAT, 8'h0f);
      b = 8'($random(seed));
      put(`OFS_DATA, b);
      tx_grab(got);
      `compare_eq(got, b)
      expect_rd(`OFS_LSR, 8'h60);
      `compare_eq(irq, 1'b0)
      put(`OFS_IMASK, 8'h04);
      expect_rd(`OFS_ISTAT, 8'h04);
      `compare_eq(irq, 1'b1)
      expect_rd(`OFS_IIR, 8'h02);
      expect_rd(`OFS_IIR, 8'h01);
      put(`OFS_ISTAT, 8'h04);
      expect_rd(`OFS_ISTAT, 8'h00);
      `compare_eq(irq, 1'b0)
      put(`OFS_MCR, 8'h03);
      expect_rd(`OFS_MCR, 8'h03);
      `compare_eq({rts_n, dtr_n}, 2'b00)
      put(`OFS_MCR, 8'h00);
      expect_rd(`OFS_MCR, 8'h00);
      `compare_eq({rts_n, dtr_n}, 2'b11)
      put(`OFS_IER, 8'h00);
      b = 8'($random(seed));
      rx_send(b);
      expect_rd(`OFS_LSR, 8'h61);
      expect_rd(`OFS_DATA, b);
      expect_rd(`OFS_LSR, 8'h60);
      put(`OFS_IIR, 8'hc7);
      repeat (17) begin
         b = 8'($random(seed));
         if (rxq.size() < 16) rxq.push_back(b);
         rx_send(b);
      end
      expect_rd(`OFS_LSR, 8'h63);
      while (rxq.size() > 0) expect_rd(`OFS_DATA, rxq.pop_front());
      expect_rd(`OFS_LSR, 8'h60);
      test_done();
   end
endmodule

// ===== verification/uart_checker.sv
// ====
// port-level checks on the channel
module uart_checker (
   input wire clock,
   input wire rst_b,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [5:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire serial_out,
   input wire rts_n,
   input wire dtr_n,
   input wire irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   // reset is the cause here, so it must not disable this one
   a_reset_quiet: assert property (disable iff (1'b0) !rst_b |=>
      !s_axi_bvalid && !s_axi_rvalid && serial_out && rts_n && dtr_n && !irq)
      else $error("outputs not idle after reset");
   a_read_latency: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read answer dropped early");
   a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped early");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
      else $error("write answer missing");
   a_upper_zero: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_unmapped_error: assert property (s_axi_arvalid && s_axi_arready &&
      s_axi_araddr[5:2] > 4'h9 |=> s_axi_rresp == 2'b10)
      else $error("unmapped read not refused");
   a_start_bit: assert property (
      $fell(serial_out) |-> !serial_out [*8])
      else $error("start bit too short");
   cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
   cover property ($rose(irq));
   cover property ($fell(serial_out));
endmodule
bind uart_channel uart_checker uart_checker_i (.*);
